// >>> hdl/bts_sequencer.sv
// Multiple-register load and store sequencer with its control port.
`timescale 1ns/1ps
`include "bts_consts.svh"
// How it works
// - A failed condition ends the instruction with no register or memory change.
// - The register list is a 16-bit mask, bit i selecting register i.
// - Storing the program counter writes the instruction address plus 12.
// - Registers move in ascending order, lowest register at lowest address.
// - Addresses follow base, pre/post and up/down: four stepping modes.
// - Without write-back the base keeps its value unless a load overwrites it.
// - Unaligned base bits pass unchanged onto the low address outputs.
// - Load with status bit and program counter copies saved into current status.
// - Store with status bit and program counter reads the user bank.
// - Status bit without program counter moves user bank registers either way.
// - Write-back lands at end of cycle two; later stored bases show it.
// - A loaded base word replaces the written-back base value.
// - A store abort runs to the end, keeps write-back, then traps.
// - A load abort stops register writes from the aborting transfer on.
// - After a load abort the base returns to written-back or original value.
// - A load abort traps only after the whole sequence has finished.
// - Load takes nS+1N+1I, or (n+1)S+2N+1I when loading the counter.
// - Store takes (n-1)S plus 2N cycles.
// - Load bit 1 loads, pre bit 1 indexes first, up bit 1 ascends.
module bts_sequencer
    import bts_pkg::*;
#(
    parameter int RLIST_W = 16,
    parameter int DATA_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_cond_pass,
    input wire logic [RLIST_W-1:0] i_rlist,
    input wire logic i_load,
    input wire logic i_pre,
    input wire logic i_up,
    input wire logic i_wb,
    input wire logic i_sbit,
    input wire logic [3:0] i_base_num,
    input wire logic [DATA_W-1:0] i_base_val,
    input wire logic [DATA_W-1:0] i_instr_addr,
    output logic o_busy,
    output logic o_done,
    output logic o_abort_trap,
    output logic [3:0] o_rf_rd_idx,
    output logic o_rf_rd_user,
    input wire logic [DATA_W-1:0] i_rf_rd_data,
    output logic o_rf_wr_en,
    output logic [3:0] o_rf_wr_idx,
    output logic o_rf_wr_user,
    output logic [DATA_W-1:0] o_rf_wr_data,
    output logic o_psr_restore,
    output logic o_mem_req,
    output logic o_mem_wr,
    output bts_cyc_t o_cyc_type,
    output logic [DATA_W-1:0] o_mem_addr,
    output logic [DATA_W-1:0] o_mem_wdata,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic i_abort,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata
);
    bts_state_s_t q;
    bts_state_s_t nxt;
    logic pick_found;
    logic [3:0] pick_idx;
    logic [4:0] n_words;
    logic [31:0] span;
    logic [31:0] st_data;
    logic abort_now;

    bts_low_pick #(
        .W(RLIST_W),
        .IW(4)
    ) u_pick (
        .i_mask(q.left),
        .o_found(pick_found),
        .o_idx(pick_idx)
    );

    always_comb begin
        n_words = 5'h0;
        for (int i = 0; i < RLIST_W; i++) begin
            n_words = n_words + 5'(i_rlist[i]);
        end
        span = {25'h0, n_words, 2'h0};
    end

    // The first stored register predates the write-back commit, later ones
    // see it, so the base is substituted from the captured final value.
    always_comb begin
        if (pick_idx == `BTS_PC_IDX) begin
            st_data = q.pc_val;
        end else if (pick_idx == q.base_num && q.wb && q.state != ST_ADDR) begin
            st_data = q.base_final;
        end else begin
            st_data = i_rf_rd_data;
        end
    end

    assign abort_now = q.aborted | i_abort;

    always_comb begin
        nxt = q;
        nxt.wr_en = 1'b0;
        nxt.psr_restore = 1'b0;
        nxt.trap = 1'b0;
        nxt.done = 1'b0;
        if (q.state != ST_IDLE) begin
            nxt.cyc_cnt = q.cyc_cnt + 8'h01;
        end
        unique case (q.state)
            ST_IDLE: begin
                if (i_start && q.ctrl_en) begin
                    if (!i_cond_pass) begin
                        nxt.done = 1'b1;
                    end else begin
                        nxt.state = ST_ADDR;
                        nxt.left = i_rlist;
                        nxt.load = i_load;
                        nxt.sbit = i_sbit;
                        nxt.wb = i_wb;
                        nxt.pc_in = i_rlist[`BTS_PC_IDX];
                        nxt.user = i_sbit && !(i_load && i_rlist[`BTS_PC_IDX]);
                        nxt.first = 1'b1;
                        nxt.aborted = 1'b0;
                        nxt.base_num = i_base_num;
                        nxt.base_orig = i_base_val;
                        nxt.pc_val = i_instr_addr + `BTS_PC_OFFSET;
                        nxt.cyc_cnt = 8'h01;
                        // Low address bits ride through untouched.
                        if (i_up) begin
                            nxt.base_final = i_base_val + span;
                            nxt.addr = i_pre ? i_base_val + `BTS_WORD_BYTES
                                             : i_base_val;
                        end else begin
                            nxt.base_final = i_base_val - span;
                            nxt.addr = i_pre ? i_base_val - span
                                : i_base_val - span + `BTS_WORD_BYTES;
                        end
                    end
                end
            end
            ST_ADDR: begin
                // Write-back commits at the end of cycle two.
                nxt.wr_en = q.wb;
                nxt.wr_idx = q.base_num;
                nxt.wr_user = 1'b0;
                nxt.wr_data = q.base_final;
                if (pick_found) begin
                    nxt.state = ST_XFER;
                    nxt.cur_idx = pick_idx;
                    nxt.left[pick_idx] = 1'b0;
                    nxt.wdata = st_data;
                end else begin
                    // An empty list is illegal; it retires without traffic.
                    nxt.state = ST_IDLE;
                    nxt.done = 1'b1;
                    nxt.last_cnt = q.cyc_cnt;
                end
            end
            ST_XFER: begin
                nxt.first = 1'b0;
                nxt.aborted = abort_now;
                if (q.load && !abort_now) begin
                    nxt.wr_en = 1'b1;
                    nxt.wr_idx = q.cur_idx;
                    nxt.wr_user = q.user;
                    nxt.wr_data = i_mem_rdata;
                    nxt.psr_restore = q.sbit && q.cur_idx == `BTS_PC_IDX;
                end
                if (pick_found) begin
                    nxt.cur_idx = pick_idx;
                    nxt.left[pick_idx] = 1'b0;
                    nxt.addr = q.addr + `BTS_WORD_BYTES;
                    nxt.wdata = st_data;
                end else if (q.load) begin
                    nxt.state = ST_INTL;
                    if (abort_now) begin
                        // The base may have been overwritten before the
                        // abort, so it is put back here.
                        nxt.wr_en = 1'b1;
                        nxt.wr_idx = q.base_num;
                        nxt.wr_user = 1'b0;
                        nxt.wr_data = q.wb ? q.base_final : q.base_orig;
                    end
                end else begin
                    // Stores keep running after an abort.
                    nxt.state = ST_IDLE;
                    nxt.done = 1'b1;
                    nxt.trap = abort_now;
                    nxt.last_abort = abort_now;
                    nxt.last_cnt = q.cyc_cnt;
                end
            end
            ST_INTL: begin
                if (q.pc_in && !q.aborted) begin
                    nxt.state = ST_FIL1;
                end else begin
                    nxt.state = ST_IDLE;
                    nxt.done = 1'b1;
                    nxt.trap = q.aborted;
                    nxt.last_abort = q.aborted;
                    nxt.last_cnt = q.cyc_cnt;
                end
            end
            ST_FIL1: begin
                nxt.state = ST_FIL2;
            end
            ST_FIL2: begin
                nxt.state = ST_IDLE;
                nxt.done = 1'b1;
                nxt.last_abort = 1'b0;
                nxt.last_cnt = q.cyc_cnt;
            end
            default: begin
                nxt.state = ST_IDLE;
            end
        endcase
        if (i_reg_wr && i_reg_addr == `BTS_ADDR_CTRL) begin
            nxt.ctrl_en = i_reg_wdata[`BTS_CTRL_EN_BIT];
        end
        nxt.rdata = 32'h0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `BTS_ADDR_CTRL: nxt.rdata[`BTS_CTRL_EN_BIT] = q.ctrl_en;
                `BTS_ADDR_STAT: begin
                    nxt.rdata[`BTS_STAT_BUSY_BIT] = q.state != ST_IDLE;
                    nxt.rdata[`BTS_STAT_ABT_BIT] = q.last_abort;
                end
                `BTS_ADDR_CNT: nxt.rdata[7:0] = q.last_cnt;
                default: nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.ctrl_en <= `BTS_CTRL_EN_RESET;
        end else begin
            q <= nxt;
        end
    end

    assign o_busy = q.state != ST_IDLE;
    assign o_done = q.done;
    assign o_abort_trap = q.trap;
    assign o_rf_rd_idx = pick_idx;
    assign o_rf_rd_user = q.user;
    assign o_rf_wr_en = q.wr_en;
    assign o_rf_wr_idx = q.wr_idx;
    assign o_rf_wr_user = q.wr_user;
    assign o_rf_wr_data = q.wr_data;
    assign o_psr_restore = q.psr_restore;
    assign o_mem_req = q.state == ST_XFER;
    assign o_mem_wr = q.state == ST_XFER && !q.load;
    assign o_mem_addr = q.addr;
    assign o_mem_wdata = q.wdata;
    assign o_reg_rdata = q.rdata;

    // Store data cycles start non-sequential; loads are sequential.
    always_comb begin
        unique case (q.state)
            ST_ADDR: o_cyc_type = CYC_N;
            ST_XFER: o_cyc_type = (q.first && !q.load) ? CYC_N : CYC_S;
            ST_INTL: o_cyc_type = CYC_I;
            ST_FIL1: o_cyc_type = CYC_N;
            ST_FIL2: o_cyc_type = CYC_S;
            default: o_cyc_type = CYC_NONE;
        endcase
    end

    a_cond_false_idle: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (q.state == ST_IDLE && i_start && q.ctrl_en && !i_cond_pass)
        |=> (o_done && !o_busy && !o_rf_wr_en && !o_mem_req)
    ) else $error("failed condition did not retire quietly");

    a_pc_store_val: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_mem_wr && q.cur_idx == `BTS_PC_IDX)
        |-> (o_mem_wdata == q.pc_val)
    ) else $error("stored counter is not instruction address plus 12");

    a_addr_ascends: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_mem_req && !q.first)
        |-> (o_mem_addr == $past(o_mem_addr) + `BTS_WORD_BYTES)
    ) else $error("transfer address did not step up one word");

    a_first_addr_ib: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (q.state == ST_IDLE && i_start && q.ctrl_en && i_cond_pass
         && i_up && i_pre && i_rlist != 16'h0000)
        |=> ##1 (o_mem_addr == $past(i_base_val, 2) + `BTS_WORD_BYTES)
    ) else $error("increment-before start address wrong");

    a_wb_timing: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (q.state == ST_ADDR && q.wb)
        |=> (o_rf_wr_en && o_rf_wr_idx == q.base_num
             && o_rf_wr_data == q.base_final && o_mem_req)
    ) else $error("write-back not presented in cycle two");

    a_no_pc_on_abort: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (q.state == ST_XFER && q.load && i_abort)
        |=> (!o_rf_wr_en || o_rf_wr_idx == q.base_num) && !o_psr_restore
    ) else $error("aborting load still wrote a register");

    a_psr_with_pc: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_psr_restore |-> (o_rf_wr_en && o_rf_wr_idx == `BTS_PC_IDX && q.sbit)
    ) else $error("status restore without counter load");

    a_user_bank: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_busy && q.sbit && !(q.load && q.pc_in)) |-> o_rf_rd_user
    ) else $error("user bank not selected");

    a_trap_at_end: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (q.state == ST_XFER && q.load && i_abort)
        |-> ##[1:17] (o_abort_trap && o_done && !o_busy)
    ) else $error("load abort trap missing at end of sequence");

    a_store_abort_end: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_abort_trap && !q.load) |-> (o_done && $past(o_mem_wr))
    ) else $error("store abort trapped before the last store");
endmodule : bts_sequencer

// >>> hdl/bts_consts.svh
// Named offsets, field positions, reset values and fixed figures.
`ifndef BTS_CONSTS_SVH
`define BTS_CONSTS_SVH
`define BTS_ADDR_CTRL 4'h0
`define BTS_ADDR_STAT 4'h4
`define BTS_ADDR_CNT 4'h8
`define BTS_CTRL_EN_BIT 0
`define BTS_CTRL_EN_RESET 1'b1
`define BTS_STAT_BUSY_BIT 0
`define BTS_STAT_ABT_BIT 1
`define BTS_PC_OFFSET 32'h0000000C
`define BTS_WORD_BYTES 32'h00000004
`define BTS_PC_IDX 4'hF
`endif

// >>> hdl/bts_pkg.sv
// Types shared by the block transfer sequencer.
package bts_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_XFER = 3'h3,
        ST_INTL = 3'h2,
        ST_FIL1 = 3'h6,
        ST_FIL2 = 3'h7
    } bts_state_t;

    typedef enum logic [1:0] {
        CYC_NONE = 2'h0,
        CYC_N = 2'h1,
        CYC_S = 2'h2,
        CYC_I = 2'h3
    } bts_cyc_t;

    typedef struct packed {
        bts_state_t state;
        logic [15:0] left;
        logic load;
        logic sbit;
        logic wb;
        logic pc_in;
        logic user;
        logic first;
        logic aborted;
        logic [3:0] base_num;
        logic [3:0] cur_idx;
        logic [31:0] base_orig;
        logic [31:0] base_final;
        logic [31:0] pc_val;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr_en;
        logic wr_user;
        logic [3:0] wr_idx;
        logic [31:0] wr_data;
        logic psr_restore;
        logic trap;
        logic done;
        logic ctrl_en;
        logic last_abort;
        logic [7:0] cyc_cnt;
        logic [7:0] last_cnt;
        logic [31:0] rdata;
    } bts_state_s_t;
endpackage : bts_pkg

// >>> hdl/bts_low_pick.sv
// Finds the lowest set bit of a mask and returns its index.
`timescale 1ns/1ps
module bts_low_pick #(
    parameter int W = 16,
    parameter int IW = 4
) (
    input wire logic [W-1:0] i_mask,
    output logic o_found,
    output logic [IW-1:0] o_idx
);
    always_comb begin
        o_found = 1'b0;
        o_idx = '0;
        // Scanning downward lets the lowest set bit win last.
        for (int i = W - 1; i >= 0; i--) begin
            if (i_mask[i]) begin
                o_found = 1'b1;
                o_idx = IW'(i);
            end
        end
    end
endmodule : bts_low_pick

// >>> dv/bts_mem_model.sv
// Memory system and memory manager model facing the sequencer bus.
`timescale 1ns/1ps
module bts_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [31:0] i_addr,
    input wire logic i_ab_en,
    input wire logic [31:0] i_ab_addr,
    output logic [31:0] o_rdata,
    output logic o_abort
);
    logic [31:0] mem[64];
    logic [31:0] last_ff = 32'h0;
    logic seen_ff = 1'h0;
    // Outside a read the bus shows the inverse of its last value.
    assign o_rdata = (i_req && !i_wr) ? {16'hA5A5, i_addr[15:0]} : ~last_ff;
    assign o_abort = i_req && i_ab_en && i_addr == i_ab_addr;
    always @(posedge i_clk) begin
        last_ff <= o_rdata;
        seen_ff <= i_ab_en && (seen_ff || o_abort);
        // The sequencer keeps storing after an abort, so writes drop here.
        if (i_req && i_wr && !o_abort && !seen_ff) begin
            mem[i_addr[7:2]] <= ~i_addr;
        end
    end
endmodule : bts_mem_model

// >>> dv/bts_sequencer_tb_top.sv
// Self-checking bench for the block transfer sequencer.
`timescale 1ns/1ps
module bts_sequencer_tb_top;
    import bts_pkg::*;
    logic i_clk = 1'h0, i_rst = 1'h1, i_start = 1'h0, i_cond_pass = 1'h0;
    logic i_load = 1'h0, i_pre = 1'h0, i_up = 1'h0, i_wb = 1'h0;
    logic i_sbit = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, ab_en = 1'h0;
    logic [15:0] i_rlist = 16'h0;
    logic [3:0] i_base_num = 4'h0, i_reg_addr = 4'h0;
    logic [31:0] i_base_val = 32'h0, i_instr_addr = 32'h2000;
    logic [31:0] i_reg_wdata = 32'h0, ab_addr = 32'h0;
    logic [31:0] i_rf_rd_data, i_mem_rdata, o_rf_wr_data, o_mem_addr;
    logic [31:0] o_mem_wdata, o_reg_rdata;
    logic [3:0] o_rf_rd_idx, o_rf_wr_idx;
    logic i_abort, o_busy, o_done, o_abort_trap, o_rf_rd_user, o_rf_wr_en;
    logic o_rf_wr_user, o_psr_restore, o_mem_req, o_mem_wr;
    bts_cyc_t o_cyc_type;
    logic [31:0] rf_sh[16];
    logic rf_us[16];
    int n_mismatch = 0, compares = 0, ticks = 0;
    always #5 i_clk = ~i_clk;
    // Register file stand-in: the base reads its value, others a bank code.
    assign i_rf_rd_data = (o_rf_rd_idx == i_base_num) ? i_base_val :
        {o_rf_rd_user ? 4'hC : 4'hB, 24'h0, o_rf_rd_idx};
    always @(posedge i_clk) begin
        ticks <= ticks + 1;
        if (o_rf_wr_en) begin
            rf_sh[o_rf_wr_idx] <= o_rf_wr_data;
            rf_us[o_rf_wr_idx] <= o_rf_wr_user;
        end
        if (ticks == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    bts_sequencer i_dut (.i_clk, .i_rst, .i_start, .i_cond_pass, .i_rlist,
        .i_load, .i_pre, .i_up, .i_wb, .i_sbit, .i_base_num, .i_base_val,
        .i_instr_addr, .o_busy, .o_done, .o_abort_trap, .o_rf_rd_idx,
        .o_rf_rd_user, .i_rf_rd_data, .o_rf_wr_en, .o_rf_wr_idx, .o_rf_wr_user,
        .o_rf_wr_data, .o_psr_restore, .o_mem_req, .o_mem_wr, .o_cyc_type,
        .o_mem_addr, .o_mem_wdata, .i_mem_rdata, .i_abort, .i_reg_addr,
        .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
    bts_mem_model i_mem (.i_clk, .i_req(o_mem_req), .i_wr(o_mem_wr),
        .i_addr(o_mem_addr), .i_ab_en(ab_en), .i_ab_addr(ab_addr),
        .o_rdata(i_mem_rdata), .o_abort(i_abort));
    task automatic end_of_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] ex, got);
        compares++;
        if (got !== ex) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, ex, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'h1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'h0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] ex);
        @(posedge i_clk);
        i_reg_rd <= 1'h1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'h0;
        #1;
        chk("reg port", ex, o_reg_rdata);
    endtask : reg_rd
    // One instruction; ab is the transfer that aborts, negative for none.
    task automatic run(input logic ld, pr, up, wb, sb, cp,
        input logic [15:0] rl, input logic [3:0] bn, input logic [31:0] bv,
        input int ab);
        int n = 0, t = 0, cyc = 1, nn = 0, ns = 0, ni = 0;
        int pos[16];
        logic [3:0] rg[16];
        logic [31:0] a0, fin, ex;
        logic pc, rpc, ps = 1'h0, tr = 1'h0;
        for (int r = 0; r < 16; r++) begin
            rf_sh[r] = 32'hEEEEEEEE;
            if (rl[r]) begin
                rg[n] = r;
                pos[r] = n;
                n++;
            end
        end
        pc = rl[15];
        rpc = pc && ab < 0;
        fin = up ? bv + 4 * n : bv - 4 * n;
        a0 = up ? (pr ? bv + 4 : bv) : (pr ? fin : fin + 4);
        @(posedge i_clk);
        ab_en <= ab >= 0;
        ab_addr <= a0 + 4 * ab;
        i_start <= 1'h1;
        {i_load, i_pre, i_up, i_wb, i_sbit, i_cond_pass} <= {ld, pr, up, wb, sb, cp};
        i_rlist <= rl;
        i_base_num <= bn;
        i_base_val <= bv;
        @(posedge i_clk);
        i_start <= 1'h0;
        forever begin
            #1;
            if (o_done || cyc > 40) break;
            nn += o_cyc_type == CYC_N;
            ns += o_cyc_type == CYC_S;
            ni += o_cyc_type == CYC_I;
            if (o_mem_req && t < n) begin
                chk("addr", a0 + 4 * t, o_mem_addr);
                ex = rg[t] == 15 ? i_instr_addr + 12 : rg[t] == bn ?
                    (t == 0 || !wb ? bv : fin) : {sb ? 4'hC : 4'hB, 24'h0, rg[t]};
                if (!ld) chk("wdata", ex, o_mem_wdata);
                t++;
            end
            ps |= o_psr_restore;
            tr |= o_abort_trap;
            @(posedge i_clk);
            cyc++;
        end
        chk("cycles", !cp ? 1 : !ld ? n + 2 : rpc ? n + 5 : n + 3, cyc);
        chk("n cycles", !cp ? 0 : ld ? 1 + rpc : 2, nn);
        chk("s cycles", !cp ? 0 : ld ? n + rpc : n - 1, ns);
        chk("i cycles", cp && ld, ni);
        chk("transfers", cp ? n : 0, t);
        chk("early trap", 0, tr);
        chk("trap", cp && ab >= 0, o_abort_trap);
        chk("status copy", ld && sb && rpc, ps);
        for (int r = 0; r < 16; r++) begin
            ex = 32'hEEEEEEEE;
            if (cp && ld && rl[r] && (ab < 0 || pos[r] < ab))
                ex = {16'hA5A5, 16'(a0 + 4 * pos[r])};
            if (cp && r == bn && ld && ab >= 0) ex = wb ? fin : bv;
            else if (cp && r == bn && wb && !(ld && rl[r])) ex = fin;
            chk("register", ex, rf_sh[r]);
            if (ex[31:16] == 16'hA5A5 && r != bn)
                chk("bank", sb && !pc, rf_us[r]);
        end
    endtask : run
    task automatic t_regs();
        reg_rd(4'h0, 32'h1);
        reg_rd(4'h4, 32'h0);
        reg_wr(4'hC, 32'hFFFFFFFF);
        reg_rd(4'hC, 32'h0);
        reg_wr(4'h0, 32'h0);
        @(posedge i_clk);
        i_start <= 1'h1;
        i_cond_pass <= 1'h1;
        i_rlist <= 16'h0002;
        @(posedge i_clk);
        i_start <= 1'h0;
        #1;
        chk("busy", 0, o_busy);
        reg_wr(4'h0, 32'h1);
    endtask : t_regs
    task automatic t_modes();
        for (int m = 0; m < 8; m++)
            run(m[2], m[1], m[0], 1, 0, 1, 16'h00A2, 4'h2, 32'h1000, -1);
    endtask : t_modes
    task automatic t_base();
        run(0, 0, 1, 1, 0, 1, 16'h0218, 4'h3, 32'h1000, -1);
        run(0, 0, 1, 1, 0, 1, 16'h0218, 4'h4, 32'h1000, -1);
        run(0, 1, 0, 0, 0, 1, 16'h8001, 4'h2, 32'h1000, -1);
        run(1, 0, 1, 1, 0, 1, 16'h0044, 4'h2, 32'h1002, -1);
        run(1, 1, 1, 0, 0, 1, 16'h0084, 4'h2, 32'h1000, -1);
    endtask : t_base
    task automatic t_sbit();
        run(1, 0, 1, 0, 1, 1, 16'h8003, 4'h4, 32'h1000, -1);
        run(0, 1, 0, 0, 1, 1, 16'h8006, 4'h4, 32'h1000, -1);
        run(1, 0, 1, 0, 1, 1, 16'h0060, 4'h4, 32'h1000, -1);
        run(0, 0, 1, 0, 1, 1, 16'h0060, 4'h4, 32'h1000, -1);
    endtask : t_sbit
    task automatic t_abort();
        run(0, 0, 1, 1, 0, 1, 16'h00A2, 4'h2, 32'h1000, 1);
        run(1, 0, 1, 0, 0, 1, 16'h801A, 4'h3, 32'h1000, 2);
        reg_rd(4'h4, 32'h2);
        run(1, 0, 1, 1, 0, 1, 16'h801A, 4'h3, 32'h1000, 2);
        run(0, 0, 1, 1, 0, 0, 16'h00A2, 4'h2, 32'h1000, -1);
    endtask : t_abort
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        t_regs();
        t_modes();
        t_base();
        t_sbit();
        t_abort();
        end_of_test();
    end
endmodule : bts_sequencer_tb_top
